// >>> hw/mub_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
interface mub_bus_if;
	logic [1:0] phase;
	logic [7:0] hostData;
	logic       hostOeHi;
	logic       hostOeLo;
	logic       ioEnable;
	logic [3:0] devData;
	logic       devOe;
	logic       irqReq;
	logic [7:0] busLine;

	// Idle bus floats to all ones; host wins a clash on the low nibble
	assign busLine[7:4] = hostOeHi ? hostData[7:4] : 4'hF;
	assign busLine[3:0] = hostOeLo ? hostData[3:0] : (devOe ? devData : 4'hF);

	modport host (output phase, hostData, hostOeHi, hostOeLo, ioEnable,
		input busLine, irqReq);
	modport device (input phase, busLine, ioEnable, output devData, devOe, irqReq);
endinterface
`default_nettype wire

// >>> hw/mub_defs.svh
`ifndef MUB_DEFS_SVH
`define MUB_DEFS_SVH

// System clock
`define MUB_CLK_HZ        25000000
`define MUB_CLK_MHZ       25

// Bit time at the top rate, and its derived cycle count (rounded down)
`define MUB_BIT_NS_1200   833333
`define MUB_BIT_CYCLES    (`MUB_BIT_NS_1200 * `MUB_CLK_MHZ / 1000)
`define MUB_RATE_TOP      3'h5

// Tone sets: mark and space in Hz
`define MUB_MARK_A_HZ     1300
`define MUB_SPACE_A_HZ    2100
`define MUB_MARK_B_HZ     1200
`define MUB_SPACE_B_HZ    2200
`define MUB_NCO_BITS      24
`define MUB_TONE_INC(f)   (((f) * 64'h1000000) / `MUB_CLK_HZ)
`define MUB_TONE_IDLE     4'h8

// Phase numbers 1..4 carried as 0..3
`define MUB_PH1           2'h0
`define MUB_PH2           2'h1
`define MUB_PH3           2'h2
`define MUB_PH4           2'h3

// Command function codes on the low nibble of the second word
`define MUB_FN_LMT        4'h1
`define MUB_FN_LLT        4'h2
`define MUB_FN_RMR        4'h3
`define MUB_FN_RLR        4'h4
`define MUB_FN_CFG        4'h5
`define MUB_FN_STAT       4'h6
`define MUB_FN_RATE       4'h7
`define MUB_FN_RQS        4'hC

// Secondary codes for the send request
`define MUB_RQS_SPACE     4'h1
`define MUB_RQS_MARK      4'h2
`define MUB_RQS_OFF       4'h4
`define MUB_RQS_CHAR_BIT  3

// Configuration nibble fields
`define MUB_CFG_PAR_EN    0
`define MUB_CFG_PAR_ODD   1
`define MUB_CFG_HALF_DUP  2

// Misc
`define MUB_ADDR_RESERVED 4'h0
`define MUB_FIRST_WORD    8'h1C
`define MUB_CHAR_BITS     8
`define MUB_FIFO_DEPTH    16

`endif

// >>> hw/mub_device.sv
// Operation
// - Host sends command as two program words
// - First word makes host prepare enable strobe
// - First word fetched phase 2, arrives phase 4
// - Second word on bus in phase 4
// - Strobe driven with second word in phase 4
// - Upper nibble of second word is address
// - Lower nibble of second word is function
// - Exchange cycle phase 2 keeps memory off bus
// - Upper nibble in exchange is host data
// - Lower nibble in exchange returns device data
// - Bus data is inverted in both directions
// - Characters: start, eight bits, parity, stop
// - One to eight characters per frame
// - Generate parity, check parity, buffer characters
// - Strap picks one of two tone sets
// - Bit rate from zero up to 1200
// - Full duplex and half duplex switched carrier (halfDup only mutes the receiver; the carrier follows the send request)
// - Defined state after reset, no command needed
// - Service requested instead of polled
// - Mode input picks raw serial or bus
// - Selected on strap match with strobe, 00 reserved
`timescale 1ns/10ps
`default_nettype none
`include "mub_defs.svh"
module mub_device
	import mub_pkg::*;
#(
	parameter int BIT_CYCLES = `MUB_BIT_CYCLES,
	parameter int FIFO_DEPTH = `MUB_FIFO_DEPTH
) (
	mub_bus_if.device  bus,
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] addrStrap,
	input  wire logic       modeSerial,
	input  wire logic       toneSetAlt,
	input  wire logic       serialIn,
	input  wire logic       txOnIn,
	input  wire logic       rxLine,
	output logic [3:0]      toneStep,
	output logic            carrierOn,
	output logic            serialOut
);
	localparam int CB = `MUB_CHAR_BITS;
	localparam logic [23:0] INC_MARK_A  = 24'(`MUB_TONE_INC(`MUB_MARK_A_HZ));
	localparam logic [23:0] INC_SPACE_A = 24'(`MUB_TONE_INC(`MUB_SPACE_A_HZ));
	localparam logic [23:0] INC_MARK_B  = 24'(`MUB_TONE_INC(`MUB_MARK_B_HZ));
	localparam logic [23:0] INC_SPACE_B = 24'(`MUB_TONE_INC(`MUB_SPACE_B_HZ));

	typedef struct packed {
		logic [2:0][2:0] pinSync;
		logic [2:0]      pinLevel;
		logic            sel;
		logic [3:0]      func;
		logic [3:0]      txHi;
		logic            parEn;
		logic            parOdd;
		logic            halfDup;
		logic [2:0]      rate;
		mub_txmode_t     txMode;
		logic [2:0]      chars;
		mub_ser_t        txSt;
		logic [CB-1:0]   txSh;
		logic [2:0]      txBit;
		logic [2:0]      txCnt;
		logic            txPar;
		logic [19:0]     txTimer;
		mub_ser_t        rxSt;
		logic [CB-1:0]   rxSh;
		logic [2:0]      rxBit;
		logic [2:0]      rxCnt;
		logic            rxPar;
		logic [19:0]     rxTimer;
		logic [CB-1:0]   rxHold;
		logic            rxAvail;
		logic            parErr;
		logic [23:0]     nco;
		logic [3:0]      toneStep;
		logic            carrier;
		logic            serialOut;
		logic [3:0]      devData;
		logic            devOe;
		logic            irq;
	} mub_dev_t;

	mub_dev_t s, n;
	logic          fifoInValid;
	logic          fifoInReady;
	logic [CB-1:0] fifoInData;
	logic          fifoOutValid;
	logic          fifoOutReady;
	logic [CB-1:0] fifoOutData;

	// Bit period for a rate code; code 0 (or beyond the top) stops the clock
	function automatic logic [19:0] bitPeriod(input logic [2:0] r);
		if (r == 3'h0 || r > `MUB_RATE_TOP) begin
			return 20'h0;
		end
		return 20'(BIT_CYCLES << (`MUB_RATE_TOP - r));
	endfunction

	// Sixteen-step sine approximation for the summing network
	function automatic logic [3:0] sineStep(input logic [3:0] p);
		logic [63:0] tbl;
		tbl = 64'h53212358BDEFEDB8;
		return tbl[p*4 +: 4];
	endfunction

	// Drain side stalls while the serialiser is busy, so the buffer really fills
	mub_fifo #(
		.WIDTH (CB),
		.DEPTH (FIFO_DEPTH)
	) txFifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.inData   (fifoInData),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOutData)
	);

	// Next-state logic for bus port, serialiser, receiver and modulator
	always_comb begin
		logic [19:0] per;
		logic        txLine;
		logic        charMode;
		logic        rxOn;
		logic [3:0]  d;
		n = s;
		per = bitPeriod(s.rate);
		txLine = 1'b1;
		d = 4'h0;
		fifoInValid = 1'b0;
		fifoInData = {s.txHi, ~bus.busLine[7:4]};
		fifoOutReady = 1'b0;
		charMode = !modeSerial && s.txMode == TM_CHAR;

		// Three-flop pin capture; a level changes once flops two and three agree
		for (int i = 0; i < 3; i++) begin
			n.pinSync[i] = {s.pinSync[i][1:0], (i == 0) ? rxLine : (i == 1) ? serialIn : txOnIn};
			if (s.pinSync[i][1] == s.pinSync[i][2]) begin
				n.pinLevel[i] = s.pinSync[i][2];
			end
		end

		// Command word on phase 4 with strobe; reserved address never matches
		if (bus.phase == `MUB_PH4 && bus.ioEnable) begin
			n.sel = !modeSerial && bus.busLine[7:4] == addrStrap
				&& addrStrap != `MUB_ADDR_RESERVED;
			n.func = bus.busLine[3:0];
			unique case (bus.busLine[3:0])
				`MUB_FN_RMR: n.devData = ~s.rxHold[7:4];
				`MUB_FN_RLR: n.devData = ~s.rxHold[3:0];
				`MUB_FN_STAT: n.devData = ~{s.rxAvail, s.parErr, !fifoInReady,
					s.txSt != SER_IDLE};
				default: n.devData = 4'hF;
			endcase
		end
		// Drive low nibble only for reads, only while selected
		if (bus.phase == `MUB_PH1) begin
			n.devOe = s.sel && (s.func == `MUB_FN_RMR || s.func == `MUB_FN_RLR
				|| s.func == `MUB_FN_STAT);
		end
		// Exchange in phase 2: host nibble arrives inverted
		if (bus.phase == `MUB_PH2) begin
			n.devOe = 1'b0;
			n.sel = 1'b0;
			if (s.sel && bus.ioEnable) begin
				d = ~bus.busLine[7:4];
				unique case (s.func)
					`MUB_FN_LMT: n.txHi = d;
					`MUB_FN_LLT: fifoInValid = 1'b1;
					`MUB_FN_RLR: n.rxAvail = 1'b0;
					`MUB_FN_CFG: begin
						n.parEn = d[`MUB_CFG_PAR_EN];
						n.parOdd = d[`MUB_CFG_PAR_ODD];
						n.halfDup = d[`MUB_CFG_HALF_DUP];
					end
					`MUB_FN_RATE: n.rate = d[2:0];
					`MUB_FN_RQS: begin
						if (d[`MUB_RQS_CHAR_BIT]) begin
							n.txMode = TM_CHAR;
							n.chars = d[2:0];
						end else if (d == `MUB_RQS_SPACE) begin
							n.txMode = TM_SPACE;
						end else if (d == `MUB_RQS_MARK) begin
							n.txMode = TM_MARK;
						end else if (d == `MUB_RQS_OFF) begin
							n.txMode = TM_OFF;
						end
					end
					default: ;
				endcase
			end
		end

		// Character serialiser: start, data LSB first, parity, next or stop
		if (s.txTimer != 20'h0) begin
			n.txTimer = s.txTimer - 20'h1;
		end
		unique case (s.txSt)
			SER_IDLE: begin
				if (charMode && fifoOutValid && per != 20'h0) begin
					fifoOutReady = 1'b1;
					n.txSh = fifoOutData;
					n.txCnt = s.chars;
					n.txSt = SER_START;
					n.txTimer = per - 20'h1;
				end
			end
			SER_START: begin
				txLine = 1'b0;
				if (s.txTimer == 20'h0 && per != 20'h0) begin
					n.txSt = SER_DATA;
					n.txBit = 3'h0;
					n.txPar = s.parOdd;
					n.txTimer = per - 20'h1;
				end
			end
			SER_DATA, SER_PAR: begin
				txLine = s.txSt == SER_PAR ? s.txPar : s.txSh[0];
				if (s.txTimer == 20'h0 && per != 20'h0) begin
					n.txTimer = per - 20'h1;
					if (s.txSt == SER_DATA) begin
						n.txPar = s.txPar ^ s.txSh[0];
						n.txSh = {1'b0, s.txSh[CB-1:1]};
						n.txBit = s.txBit + 3'h1;
					end
					if (s.txSt == SER_DATA && s.txBit == 3'h7 && s.parEn) begin
						n.txSt = SER_PAR;
					end else if (s.txSt == SER_DATA && s.txBit != 3'h7) begin
						n.txSt = SER_DATA;
					end else if (s.txCnt != 3'h0 && fifoOutValid) begin
						// Further characters share the frame's single start bit
						fifoOutReady = 1'b1;
						n.txSh = fifoOutData;
						n.txCnt = s.txCnt - 3'h1;
						n.txBit = 3'h0;
						n.txPar = s.parOdd;
						n.txSt = SER_DATA;
					end else begin
						n.txSt = SER_STOP;
					end
				end
			end
			SER_STOP: begin
				if (s.txTimer == 20'h0) begin
					n.txSt = SER_IDLE;
				end
			end
			default: n.txSt = SER_IDLE;
		endcase

		// Receiver; in half duplex it is deaf while our own carrier is up
		rxOn = charMode && per != 20'h0 && !(s.halfDup && s.carrier);
		if (s.rxTimer != 20'h0) begin
			n.rxTimer = s.rxTimer - 20'h1;
		end
		unique case (s.rxSt)
			SER_IDLE: begin
				if (rxOn && !s.pinLevel[0]) begin
					n.rxSt = SER_START;
					n.rxTimer = per >> 1;
				end
			end
			SER_START: begin
				if (s.rxTimer == 20'h0) begin
					n.rxSt = s.pinLevel[0] ? SER_IDLE : SER_DATA;
					n.rxBit = 3'h0;
					n.rxCnt = s.chars;
					n.rxPar = s.parOdd;
					n.rxTimer = per - 20'h1;
				end
			end
			SER_DATA, SER_PAR: begin
				if (s.rxTimer == 20'h0) begin
					n.rxTimer = per - 20'h1;
					if (s.rxSt == SER_DATA) begin
						n.rxSh = {s.pinLevel[0], s.rxSh[CB-1:1]};
						n.rxPar = s.rxPar ^ s.pinLevel[0];
						n.rxBit = s.rxBit + 3'h1;
					end
					if (s.rxSt == SER_DATA && s.rxBit != 3'h7) begin
						n.rxSt = SER_DATA;
					end else if (s.rxSt == SER_DATA && s.parEn) begin
						n.rxSt = SER_PAR;
					end else begin
						// A new character beats a same-cycle read clear
						n.rxAvail = 1'b1;
						n.rxHold = s.rxSt == SER_DATA ? n.rxSh : s.rxSh;
						n.parErr = s.rxSt == SER_PAR && s.rxPar != s.pinLevel[0];
						n.rxBit = 3'h0;
						n.rxPar = s.parOdd;
						n.rxCnt = s.rxCnt - 3'h1;
						n.rxSt = s.rxCnt != 3'h0 ? SER_DATA : SER_STOP;
					end
				end
			end
			SER_STOP: begin
				if (s.rxTimer == 20'h0) begin
					n.rxSt = SER_IDLE;
				end
			end
			default: n.rxSt = SER_IDLE;
		endcase

		// Modulator source: raw pins in serial mode, else the send request
		if (modeSerial) begin
			txLine = s.pinLevel[1];
			n.carrier = s.pinLevel[2];
			n.serialOut = s.pinLevel[0];
		end else begin
			n.carrier = s.txMode != TM_OFF;
			n.serialOut = 1'b1;
			if (s.txMode == TM_SPACE) begin
				txLine = 1'b0;
			end else if (s.txMode == TM_MARK) begin
				txLine = 1'b1;
			end
		end
		if (s.carrier) begin
			n.nco = s.nco + (toneSetAlt ? (txLine ? INC_MARK_B : INC_SPACE_B)
				: (txLine ? INC_MARK_A : INC_SPACE_A));
			n.toneStep = sineStep(s.nco[23:20]);
		end else begin
			n.nco = 24'h0;
			n.toneStep = `MUB_TONE_IDLE;
		end

		// Ask for service when a character waits or the buffer ran dry
		n.irq = !modeSerial && (n.rxAvail || (charMode && !fifoOutValid));
	end

	// Synchronous power-on state: carrier off, rate stopped, bus released
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
			s.pinSync <= '1;
			s.pinLevel <= '1;
			s.toneStep <= `MUB_TONE_IDLE;
			s.serialOut <= 1'b1;
			s.devData <= 4'hF;
		end else begin
			s <= n;
		end
	end

	assign toneStep    = s.toneStep;
	assign carrierOn   = s.carrier;
	assign serialOut   = s.serialOut;
	assign bus.devData = s.devData;
	assign bus.devOe   = s.devOe;
	assign bus.irqReq  = s.irq;
endmodule
`default_nettype wire

// >>> hw/mub_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module mub_fifo
	import mub_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wp;
		logic [AW:0]                 rp;
	} mub_fifo_t;

	mub_fifo_t s, n;
	logic [AW:0] count;

	// Extra pointer bit tells full from empty without a counter
	assign count    = s.wp - s.rp;
	assign inReady  = count != (AW+1)'(DEPTH);
	assign outValid = count != '0;
	assign outData  = s.mem[s.rp[AW-1:0]];

	always_comb begin
		n = s;
		if (inValid && inReady) begin
			n.mem[s.wp[AW-1:0]] = inData;
			n.wp = s.wp + 1'b1;
		end
		if (outValid && outReady) begin
			n.rp = s.rp + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule
`default_nettype wire

// >>> hw/mub_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "mub_defs.svh"
module mub_host
	import mub_pkg::*;
(
	mub_bus_if.host    bus,
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       cmdValid,
	output logic            cmdReady,
	input  wire logic [3:0] cmdAddr,
	input  wire logic [3:0] cmdFunc,
	input  wire logic [3:0] cmdData,
	output logic            rspValid,
	output logic [3:0]      rspData,
	output logic            irqSeen
);
	typedef struct packed {
		logic [1:0] phase;
		mub_hst_t   st;
		logic [7:0] hostData;
		logic       oeHi;
		logic       oeLo;
		logic       ioEn;
		logic [7:0] word;
		logic [3:0] acc;
		logic       ready;
		logic       rspValid;
		logic [3:0] rspData;
		logic       irq;
	} mub_host_t;

	mub_host_t s, n;

	// Outputs are set one cycle ahead so they stand in the named phase
	always_comb begin
		n = s;
		n.phase = s.phase + 2'h1;
		n.rspValid = 1'b0;
		n.irq = bus.irqReq;
		unique case (s.st)
			HS_IDLE: begin
				if (cmdValid && s.ready && s.phase == `MUB_PH4) begin
					n.word = {cmdAddr, cmdFunc};
					n.acc = cmdData;
					n.ready = 1'b0;
					n.st = HS_WORD1;
				end
			end
			HS_WORD1: begin
				// First word is fetched in phase 2 and seen in phase 4
				if (s.phase == `MUB_PH3) begin
					n.hostData = `MUB_FIRST_WORD;
					n.oeHi = 1'b1;
					n.oeLo = 1'b1;
				end else if (s.phase == `MUB_PH4) begin
					n.oeHi = 1'b0;
					n.oeLo = 1'b0;
					n.st = HS_WORD2;
				end
			end
			HS_WORD2: begin
				if (s.phase == `MUB_PH3) begin
					n.hostData = s.word;
					n.oeHi = 1'b1;
					n.oeLo = 1'b1;
					n.ioEn = 1'b1;
				end else if (s.phase == `MUB_PH4) begin
					n.oeHi = 1'b0;
					n.oeLo = 1'b0;
					n.st = HS_XFER;
				end
			end
			HS_XFER: begin
				if (s.phase == `MUB_PH1) begin
					n.hostData = {~s.acc, 4'hF};
					n.oeHi = 1'b1;
				end else if (s.phase == `MUB_PH2) begin
					n.rspData = ~bus.busLine[3:0];
					n.rspValid = 1'b1;
					n.oeHi = 1'b0;
					n.ioEn = 1'b0;
					n.ready = 1'b1;
					n.st = HS_IDLE;
				end
			end
			default: n.st = HS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
			s.ready <= 1'b1;
			s.hostData <= 8'hFF;
		end else begin
			s <= n;
		end
	end

	assign bus.phase    = s.phase;
	assign bus.hostData = s.hostData;
	assign bus.hostOeHi = s.oeHi;
	assign bus.hostOeLo = s.oeLo;
	assign bus.ioEnable = s.ioEn;
	assign cmdReady     = s.ready;
	assign rspValid     = s.rspValid;
	assign rspData      = s.rspData;
	assign irqSeen      = s.irq;
endmodule
`default_nettype wire

// >>> hw/mub_pkg.sv
package mub_pkg;

	typedef enum logic [2:0] {
		SER_IDLE  = 3'h0,
		SER_START = 3'h1,
		SER_DATA  = 3'h3,
		SER_PAR   = 3'h2,
		SER_STOP  = 3'h6
	} mub_ser_t;

	typedef enum logic [1:0] {
		TM_OFF   = 2'h0,
		TM_SPACE = 2'h1,
		TM_MARK  = 2'h3,
		TM_CHAR  = 2'h2
	} mub_txmode_t;

	typedef enum logic [1:0] {
		HS_IDLE  = 2'h0,
		HS_WORD1 = 2'h1,
		HS_WORD2 = 2'h3,
		HS_XFER  = 2'h2
	} mub_hst_t;

endpackage

// >>> verification/mub_bus_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "mub_defs.svh"
module mub_bus_sva (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [1:0] phase,
	input wire logic [7:0] hostData,
	input wire logic       hostOeHi,
	input wire logic       hostOeLo,
	input wire logic       ioEnable,
	input wire logic [3:0] devData,
	input wire logic       devOe,
	input wire logic       irqReq,
	input wire logic [7:0] busLine
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Strobe rises with the command word; exchange follows two cycles later
	sequence s_strobe_up;
		$rose(ioEnable) && hostOeHi && hostOeLo;
	endsequence
	sequence s_exchange;
		!hostOeHi ##1 hostOeHi;
	endsequence

	property p_phase_step;
		$past(rst_n) |-> phase == 2'($past(phase) + 2'h1);
	endproperty
	property p_strobe_phase;
		$rose(ioEnable) |-> s_strobe_up and phase == `MUB_PH4;
	endproperty
	property p_first_word;
		$rose(ioEnable) |-> $past(hostOeHi, 4) && $past(hostData, 4) == `MUB_FIRST_WORD;
	endproperty
	property p_strobe_len;
		s_strobe_up |-> ioEnable [*3] ##1 !ioEnable;
	endproperty
	property p_exchange;
		s_strobe_up |-> ##1 s_exchange;
	endproperty
	property p_dev_phase;
		$rose(devOe) |-> phase == `MUB_PH2 && hostOeHi;
	endproperty
	property p_dev_needs_strobe;
		devOe |-> ioEnable && !hostOeLo;
	endproperty
	property p_release;
		$fell(ioEnable) |-> !devOe && !hostOeHi;
	endproperty

	a_phase_step: assert property (p_phase_step) else $error("phase skipped");
	a_strobe_phase: assert property (p_strobe_phase) else $error("strobe phase");
	a_first_word: assert property (p_first_word) else $error("no first word");
	a_strobe_len: assert property (p_strobe_len) else $error("strobe length");
	a_exchange: assert property (p_exchange) else $error("no exchange");
	a_dev_phase: assert property (p_dev_phase) else $error("device drive phase");
	a_dev_needs_strobe: assert property (p_dev_needs_strobe) else $error("stray drive");
	a_release: assert property (p_release) else $error("bus not released");
endmodule
`default_nettype wire

// >>> verification/test_modem_uart_bus_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "mub_defs.svh"
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin num_errors++; \
	$display("BAD %s expected %h seen %h", nm, ex, gt); end end
module test_modem_uart_bus_port
	import mub_pkg::*;
;
	localparam int BITC = 16;
	localparam logic [3:0] STRAP = 4'hA;
	logic       clk, rst_n, cmdValid, cmdReady, rspValid, irqSeen;
	logic [3:0] cmdAddr, cmdFunc, cmdData, rspData, addrStrap, toneStep;
	logic       modeSerial, toneSetAlt, serialIn, txOnIn, rxLine, carrierOn, serialOut;
	int         num_errors, checked, cycles;
	logic [7:0] rxq[$];

	mub_bus_if busIf ();
	mub_host i_mub_host (.bus(busIf), .clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .cmdAddr(cmdAddr), .cmdFunc(cmdFunc), .cmdData(cmdData),
		.rspValid(rspValid), .rspData(rspData), .irqSeen(irqSeen));
	mub_device #(.BIT_CYCLES(BITC), .FIFO_DEPTH(16)) i_mub_device (.bus(busIf), .clk(clk),
		.rst_n(rst_n), .addrStrap(addrStrap), .modeSerial(modeSerial),
		.toneSetAlt(toneSetAlt), .serialIn(serialIn), .txOnIn(txOnIn), .rxLine(rxLine),
		.toneStep(toneStep), .carrierOn(carrierOn), .serialOut(serialOut));
	mub_bus_sva i_mub_bus_sva (.clk(clk), .rst_n(rst_n), .phase(busIf.phase),
		.hostData(busIf.hostData), .hostOeHi(busIf.hostOeHi), .hostOeLo(busIf.hostOeLo),
		.ioEnable(busIf.ioEnable), .devData(busIf.devData), .devOe(busIf.devOe),
		.irqReq(busIf.irqReq), .busLine(busIf.busLine));

	// Free-running clock, 40 ns period
	always #20 clk = ~clk;

	// Hang guard; the whole run needs well under this many cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One host command; cmdValid is held until the host has taken it
	task automatic cmd(input logic [3:0] a, input logic [3:0] f, input logic [3:0] d,
		output logic [3:0] r);
		int n;
		n = 0;
		@(posedge clk);
		cmdAddr <= a;
		cmdFunc <= f;
		cmdData <= d;
		cmdValid <= 1'b1;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (cmdReady !== 1'b0 && n < 40);
		@(posedge clk);
		cmdValid <= 1'b0;
		while (rspValid !== 1'b1 && n < 60) begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK("answer", 1'b1, rspValid)
		r = rspData;
	endtask

	// Start, eight bits LSB first, even parity (or its inverse), stop
	task automatic send_frame(input logic [7:0] b, input logic badPar);
		logic [10:0] bits;
		bits = {1'b1, (^b) ^ badPar, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			rxLine <= bits[i];
			repeat (BITC - 1) @(posedge clk);
		end
		repeat (2 * BITC) @(posedge clk);
	endtask

	// Upper half first, then lower half; compared with the bench queue
	task automatic read_byte;
		logic [3:0] hi, lo;
		logic [7:0] ex;
		ex = rxq.pop_front();
		cmd(STRAP, `MUB_FN_RMR, 4'h0, hi);
		cmd(STRAP, `MUB_FN_RLR, 4'h0, lo);
		`CHK("rxByte", ex, {hi, lo})
	endtask

	initial begin
		logic [3:0] r;
		logic [7:0] b;
		logic [3:0] prev;
		int moves;
		clk = 1'b0;
		rst_n = 1'b0;
		{cmdValid, modeSerial, toneSetAlt, serialIn, txOnIn} = '0;
		{cmdAddr, cmdFunc, cmdData} = '0;
		rxLine = 1'b1;
		addrStrap = STRAP;
		num_errors = 0;
		checked = 0;
		cycles = 0;
		void'($urandom(32'hF77CBD6A));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		`CHK("devOe", 1'b0, busIf.devOe)
		`CHK("carrierOn", 1'b0, carrierOn)
		`CHK("toneIdle", `MUB_TONE_IDLE, toneStep)
		`CHK("serialOut", 1'b1, serialOut)
		// Raw serial mode: line is passed through and bus commands are ignored
		@(posedge clk);
		modeSerial <= 1'b1;
		rxLine <= 1'b0;
		serialIn <= 1'($urandom);
		repeat (6) @(posedge clk);
		#1;
		`CHK("serialPass", 1'b0, serialOut)
		cmd(STRAP, `MUB_FN_RQS, `MUB_RQS_MARK, r);
		`CHK("serialNoCmd", 1'b0, carrierOn)
		@(posedge clk);
		modeSerial <= 1'b0;
		rxLine <= 1'b1;
		// Foreign and reserved addresses must not start the carrier
		cmd(4'h5, `MUB_FN_RQS, `MUB_RQS_MARK, r);
		cmd(4'h0, `MUB_FN_RQS, `MUB_RQS_MARK, r);
		`CHK("unselected", 1'b0, carrierOn)
		// Both tone sets, mark and space: carrier on and the step code moves
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			toneSetAlt <= k[1];
			cmd(STRAP, `MUB_FN_RQS, k[0] ? `MUB_RQS_SPACE : `MUB_RQS_MARK, r);
			moves = 0;
			prev = toneStep;
			repeat (2000) begin
				@(posedge clk);
				#1;
				moves += int'(toneStep !== prev);
				prev = toneStep;
			end
			`CHK("carrier", 1'b1, carrierOn)
			`CHK("toneMoves", 1'b1, moves > 0)
		end
		cmd(STRAP, `MUB_FN_RQS, `MUB_RQS_OFF, r);
		// Carrier and step code follow the mode change by one and two cycles
		repeat (3) @(posedge clk);
		#1;
		`CHK("carrierOff", 1'b0, carrierOn)
		`CHK("toneOff", `MUB_TONE_IDLE, toneStep)
		// Character mode, top rate, even parity, one character per frame
		cmd(STRAP, `MUB_FN_RATE, `MUB_RATE_TOP, r);
		cmd(STRAP, `MUB_FN_CFG, 4'h1, r);
		cmd(STRAP, `MUB_FN_RQS, 4'h8, r);
		// Request and its host copy lag the mode change
		repeat (3) @(posedge clk);
		#1;
		`CHK("irqEmpty", 1'b1, busIf.irqReq)
		`CHK("irqSeen", 1'b1, irqSeen)
		for (int k = 0; k < 4; k++) begin
			b = 8'($urandom);
			rxq.push_back(b);
			send_frame(b, k == 3);
			cmd(STRAP, `MUB_FN_STAT, 4'h0, r);
			if (k < 3) `CHK("statGood", 4'h8, r & 4'hC)
			else `CHK("statParErr", 4'h4, r & 4'h4)
			read_byte();
		end
		// Stopped rate: the transmit buffer fills, the extra push is dropped
		cmd(STRAP, `MUB_FN_RATE, 4'h0, r);
		for (int k = 0; k < 17; k++) begin
			b = 8'($urandom);
			cmd(STRAP, `MUB_FN_LMT, b[7:4], r);
			cmd(STRAP, `MUB_FN_LLT, b[3:0], r);
		end
		cmd(STRAP, `MUB_FN_STAT, 4'h0, r);
		`CHK("fifoFull", 4'h2, r & 4'h2)
		`CHK("irqFilled", 1'b0, busIf.irqReq)
		print_verdict();
	end
endmodule
`default_nettype wire
